// >>> spi_rate_status_data_regs.sv
/*
 * Serial peripheral core: bit rate divider, status flags, double
 * buffered data register, master shifter and interrupt.
 * Assumes one 100 MHz bus clock, a synchronous active-high reset,
 * and a single-cycle strobe register port with read data one cycle
 * after the read strobe. Link pins are sampled through three flops.
 */
// Functional notes
// - Bits 6:4 of rate register pick one of eight prescale divisors.
// - Bits 2:0 pick one of eight rate divisors giving master bit clock.
// - Rate register may be read or written at any time.
// - Receive-full set at transfer end; flag read then data read clears.
// - Transmit-empty set while room; flag read then data write clears.
// - Data writes without prior flag read showing empty are dropped.
// - Interrupt raised while transmit-empty and its enable are both set.
// - Byte entering shifter sets transmit-empty; idle within two cycles.
// - At byte end a queued byte loads the shifter, else nothing moves.
// - Mode fault on select low if master, fault on, select out off.
// - Mode fault cleared only by flag read then control one write.
// - Data reads give receive buffer, writes load transmit; resets zero.
// - In master mode loading transmit buffer starts a transfer.
// - Overrun keeps the old receive byte and drops the new one.
// - Eight bits exchanged per transfer, then byte to receive buffer.
// - Most significant bit first unless lsb-first enable is set.
// - No flag or indication is given on receive overrun.
`timescale 1ns/1ps
`include "spi_rate_consts.svh"
module spi_rate_status_data_regs (
    // Clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    // Register port
    input  wire logic [2:0]        reg_addr_i,
    input  wire spi_rate_pkg::byte_t reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output spi_rate_pkg::byte_t    reg_rdata_o,
    // Serial link
    output logic                   serial_clock_o,
    output logic                   mosi_o,
    input  wire logic              miso_i,
    input  wire logic              sel_n_i,
    output logic                   sel_n_o,
    output logic                   sel_n_oe_o,
    // Interrupt
    output logic                   irq_o
);
    import spi_rate_pkg::*;

    byte_t       ctrl1_q;
    byte_t       ctrl2_q;
    byte_t       rate_q;
    byte_t       tx_buf_q;
    byte_t       rx_buf_q;
    byte_t       shift_q;
    byte_t       rdata_q;
    logic        tx_full_q;
    logic        rx_full_q;
    logic        fault_q;
    logic        rx_armed_q;
    logic        tx_armed_q;
    logic        fault_armed_q;
    logic [2:0]  evt_q;
    logic [2:0]  mask_q;
    logic [2:0]  miso_sync_q;
    logic [2:0]  sel_sync_q;
    logic        sel_stable_q;
    logic [2:0]  pre_cnt_q;
    logic [7:0]  div_cnt_q;
    logic [3:0]  bit_cnt_q;
    logic        sample_q;
    xfer_state_t state_q;

    logic        master;
    logic        fault_watch;
    logic        half_tick;
    logic        xfer_done;
    logic        load_shift;
    logic        data_wr_ok;
    logic [2:0]  pre_max;
    logic [7:0]  div_max;
    logic        sel_fall;

    assign master      = ctrl1_q[`C1_MASTER];
    assign fault_watch = master && ctrl2_q[`C2_FAULT_EN]
                         && !ctrl1_q[`C1_SEL_OUT_EN];

    // Prescale divisor is 1..8 bus cycles, rate divisor is 2..256 prescaled ticks
    assign pre_max = rate_q[`RATE_PRE_HI:`RATE_PRE_LO];
    // Half a bit period is 2^n prescaled ticks
    assign div_max = 8'(8'h01 << rate_q[`RATE_DIV_HI:`RATE_DIV_LO])
                     - 8'h01;

    // Register writes; rate stays writable mid transfer
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl1_q <= `RESET_C1;
            ctrl2_q <= `RESET_BYTE;
            rate_q  <= `RESET_BYTE;
            mask_q  <= 3'h0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADDR_CONTROL_ONE) begin
                ctrl1_q <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_CONTROL_TWO) begin
                ctrl2_q <= reg_wdata_i;
            end else if (reg_addr_i == `ADDR_RATE) begin
                rate_q <= reg_wdata_i & `RATE_MASK;
            end else if (reg_addr_i == `ADDR_IRQ_MASK) begin
                mask_q <= reg_wdata_i[2:0];
            end
        end
    end

    // Link inputs: a select change counts once stages two and three agree
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            miso_sync_q  <= 3'h0;
            sel_sync_q   <= 3'h7;
            sel_stable_q <= 1'b1;
        end else begin
            miso_sync_q <= {miso_sync_q[1:0], miso_i};
            sel_sync_q  <= {sel_sync_q[1:0], sel_n_i};
            if (sel_sync_q[1] == sel_sync_q[2]) begin
                sel_stable_q <= sel_sync_q[2];
            end
        end
    end
    assign sel_fall = sel_stable_q && (sel_sync_q[1] == sel_sync_q[2])
                      && !sel_sync_q[2];

    // Bit clock divider: one enable pulse per half bit period
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || state_q == XF_IDLE) begin
            pre_cnt_q <= 3'h0;
            div_cnt_q <= 8'h00;
        end else if (pre_cnt_q >= pre_max) begin
            pre_cnt_q <= 3'h0;
            div_cnt_q <= (div_cnt_q >= div_max) ? 8'h00 : div_cnt_q + 8'h01;
        end else begin
            pre_cnt_q <= pre_cnt_q + 3'h1;
        end
    end
    assign half_tick = (state_q != XF_IDLE) && (pre_cnt_q >= pre_max)
                       && (div_cnt_q >= div_max);

    // Armed bits remember a status read that saw the flag set
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_armed_q    <= 1'b0;
            tx_armed_q    <= 1'b0;
            fault_armed_q <= 1'b0;
        end else begin
            if (reg_rd_i && reg_addr_i == `ADDR_FLAGS) begin
                rx_armed_q    <= rx_full_q;
                tx_armed_q    <= !tx_full_q;
                fault_armed_q <= fault_q;
            end
            if (reg_rd_i && reg_addr_i == `ADDR_DATA) begin
                rx_armed_q <= 1'b0;
            end
            if (reg_wr_i && reg_addr_i == `ADDR_DATA) begin
                tx_armed_q <= 1'b0;
            end
            if (reg_wr_i && reg_addr_i == `ADDR_CONTROL_ONE) begin
                fault_armed_q <= 1'b0;
            end
        end
    end

    // A write without the flag-read permission vanishes without a trace
    assign data_wr_ok = reg_wr_i && reg_addr_i == `ADDR_DATA
                        && tx_armed_q && !tx_full_q;
    // A queued byte takes over in the cycle the last one ends, so the
    // link never pauses between back-to-back bytes
    assign load_shift = tx_full_q && master
                        && (state_q == XF_IDLE || xfer_done);
    assign xfer_done  = half_tick && state_q == XF_TRAIL
                        && bit_cnt_q == `BITS_PER_XFER - 4'h1;

    // Transmit buffer; its emptiness is the transmit-empty flag
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tx_buf_q  <= `RESET_BYTE;
            tx_full_q <= 1'b0;
        end else if (data_wr_ok) begin
            tx_buf_q  <= reg_wdata_i;
            tx_full_q <= 1'b1;
        end else if (load_shift) begin
            tx_full_q <= 1'b0;
        end
    end

    // Master shifter: lead edge samples, trail edge shifts
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q   <= XF_IDLE;
            shift_q   <= `RESET_BYTE;
            bit_cnt_q <= 4'h0;
            sample_q  <= 1'b0;
        end else if (load_shift) begin
            state_q   <= XF_LEAD;
            shift_q   <= tx_buf_q;
            bit_cnt_q <= 4'h0;
        end else begin
            case (state_q)
                XF_IDLE: begin
                    bit_cnt_q <= 4'h0;
                end
                XF_LEAD: begin
                    if (half_tick) begin
                        sample_q <= miso_sync_q[2];
                        state_q  <= XF_TRAIL;
                    end
                end
                XF_TRAIL: begin
                    if (half_tick) begin
                        if (ctrl1_q[`C1_LSB_FIRST]) begin
                            shift_q <= {sample_q, shift_q[7:1]};
                        end else begin
                            shift_q <= {shift_q[6:0], sample_q};
                        end
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        state_q   <= xfer_done ? XF_IDLE : XF_LEAD;
                    end
                end
                default: state_q <= XF_IDLE;
            endcase
        end
    end

    // Receive buffer; an overrun keeps the old byte silently
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rx_buf_q  <= `RESET_BYTE;
            rx_full_q <= 1'b0;
        end else if (xfer_done && !rx_full_q) begin
            rx_full_q <= 1'b1;
            if (ctrl1_q[`C1_LSB_FIRST]) begin
                rx_buf_q <= {sample_q, shift_q[7:1]};
            end else begin
                rx_buf_q <= {shift_q[6:0], sample_q};
            end
        end else if (!xfer_done && rx_armed_q && reg_rd_i
                     && reg_addr_i == `ADDR_DATA) begin
            rx_full_q <= 1'b0;
        end
    end
    // Nothing records the dropped byte

    // Mode fault: set beats clear
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
        end else if (fault_watch && sel_fall) begin
            fault_q <= 1'b1;
        end else if (fault_armed_q && reg_wr_i
                     && reg_addr_i == `ADDR_CONTROL_ONE) begin
            fault_q <= 1'b0;
        end
    end

    // Sticky event bits, cleared by reading the event register
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            evt_q <= 3'h0;
        end else begin
            if (reg_rd_i && reg_addr_i == `ADDR_IRQ_STATUS) begin
                evt_q <= 3'h0;
            end
            if (xfer_done && !rx_full_q) begin
                evt_q[`EVT_RX_FULL] <= 1'b1;
            end
            if (load_shift) begin
                evt_q[`EVT_TX_EMPTY] <= 1'b1;
            end
            if (fault_watch && sel_fall) begin
                evt_q[`EVT_MODE_FAULT] <= 1'b1;
            end
        end
    end

    assign irq_o = (!tx_full_q && ctrl1_q[`C1_TX_IRQ_EN])
                   || |(evt_q & mask_q);

    // Read data, one cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_q <= `RESET_BYTE;
        end else if (reg_rd_i) begin
            if (reg_addr_i == `ADDR_CONTROL_ONE) begin
                rdata_q <= ctrl1_q;
            end else if (reg_addr_i == `ADDR_CONTROL_TWO) begin
                rdata_q <= ctrl2_q;
            end else if (reg_addr_i == `ADDR_RATE) begin
                rdata_q <= rate_q;
            end else if (reg_addr_i == `ADDR_FLAGS) begin
                rdata_q <= {rx_full_q, 1'b0, !tx_full_q, fault_q,
                            4'h0};
            end else if (reg_addr_i == `ADDR_DATA) begin
                rdata_q <= rx_buf_q;
            end else if (reg_addr_i == `ADDR_IRQ_STATUS) begin
                rdata_q <= {5'h00, evt_q};
            end else if (reg_addr_i == `ADDR_IRQ_MASK) begin
                rdata_q <= {5'h00, mask_q};
            end else begin
                rdata_q <= `RESET_BYTE;
            end
        end else begin
            rdata_q <= `RESET_BYTE;
        end
    end
    assign reg_rdata_o = rdata_q;

    // Link outputs; select out only drives with fault detect and output on
    assign serial_clock_o = (state_q == XF_TRAIL);
    assign mosi_o     = ctrl1_q[`C1_LSB_FIRST] ? shift_q[0] : shift_q[7];
    assign sel_n_o    = (state_q == XF_IDLE);
    assign sel_n_oe_o = master && ctrl2_q[`C2_FAULT_EN]
                        && ctrl1_q[`C1_SEL_OUT_EN];

    // Assertions share the bus clock and are off during reset
    default clocking assert_clk @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    idle_load_fast_a: assert property (
        data_wr_ok && state_q == XF_IDLE && master
        |-> ##[1:2] !tx_full_q && state_q == XF_LEAD)
        else $error("idle write did not reach shifter");
    drop_write_a: assert property (
        reg_wr_i && reg_addr_i == `ADDR_DATA && !tx_armed_q && !load_shift
        |=> $stable(tx_full_q))
        else $error("unarmed data write was taken");
    tx_hold_a: assert property (
        !tx_full_q && !tx_armed_q |=> !tx_full_q)
        else $error("transmit buffer filled without flag read");
    queue_move_a: assert property (
        xfer_done && tx_full_q && master
        |=> !tx_full_q && state_q == XF_LEAD)
        else $error("queued byte did not follow at once");
    rx_keep_a: assert property (
        xfer_done && rx_full_q |=> $stable(rx_buf_q) && rx_full_q)
        else $error("overrun replaced receive byte");
    rx_set_a: assert property (
        xfer_done |=> rx_full_q)
        else $error("receive flag not set at end");
    rx_hold_a: assert property (
        rx_full_q && !rx_armed_q |=> rx_full_q)
        else $error("receive flag cleared without flag read");
    fault_gate_a: assert property (
        !fault_q && !fault_watch |=> !fault_q)
        else $error("mode fault set while disabled");
    fault_hold_a: assert property (
        fault_q && !(reg_wr_i && reg_addr_i == `ADDR_CONTROL_ONE)
        |=> fault_q)
        else $error("mode fault cleared without write");
    tx_irq_a: assert property (
        !tx_full_q && ctrl1_q[`C1_TX_IRQ_EN] |-> irq_o)
        else $error("transmit interrupt missing");
    flag_zero_a: assert property (
        reg_rd_i && reg_addr_i == `ADDR_FLAGS
        |=> reg_rdata_o[3:0] == 4'h0 && !reg_rdata_o[6])
        else $error("reserved status bits nonzero");
    bit_count_a: assert property (
        state_q != XF_IDLE |-> bit_cnt_q < `BITS_PER_XFER)
        else $error("more than eight bits shifted");

    xfer_start_c: cover property (data_wr_ok ##[1:2] state_q == XF_LEAD);
    xfer_end_c: cover property (xfer_done && tx_full_q);
    overrun_c: cover property (xfer_done && rx_full_q);
    fault_c: cover property (fault_watch && sel_fall);
    lsb_xfer_c: cover property (xfer_done && ctrl1_q[`C1_LSB_FIRST]);
endmodule : spi_rate_status_data_regs

// >>> spi_rate_consts.svh
/*
 * Register offsets, field positions and reset values
 * for the serial peripheral rate, status and data registers.
 * Assumes an 8-bit register port with a 3-bit address.
 */
`ifndef SPI_RATE_CONSTS_SVH
`define SPI_RATE_CONSTS_SVH

`define ADDR_CONTROL_ONE   3'h0
`define ADDR_CONTROL_TWO   3'h1
`define ADDR_RATE          3'h2
`define ADDR_FLAGS         3'h3
`define ADDR_DATA          3'h5
`define ADDR_IRQ_STATUS    3'h6
`define ADDR_IRQ_MASK      3'h7

`define C1_TX_IRQ_EN       5
`define C1_MASTER          4
`define C1_SEL_OUT_EN      1
`define C1_LSB_FIRST       0
`define C2_FAULT_EN        4

`define RATE_PRE_HI        6
`define RATE_PRE_LO        4
`define RATE_DIV_HI        2
`define RATE_DIV_LO        0
`define RATE_MASK          8'h77

`define FLAG_RX_FULL       7
`define FLAG_TX_EMPTY      5
`define FLAG_MODE_FAULT    4

`define EVT_RX_FULL        0
`define EVT_TX_EMPTY       1
`define EVT_MODE_FAULT     2

`define RESET_BYTE         8'h00
`define RESET_C1           8'h04
`define BITS_PER_XFER      4'h8
`endif

// >>> spi_rate_pkg.sv
/*
 * Types shared by the serial rate, status and data block.
 * Assumes the constants header is compiled alongside.
 */
package spi_rate_pkg;
    typedef enum logic [1:0] {
        XF_IDLE,
        XF_LEAD,
        XF_TRAIL
    } xfer_state_t;
    typedef logic [7:0] byte_t;
endpackage : spi_rate_pkg

// >>> spi_slave_model.sv
/*
 * Behavioural far-side serial slave: shifts a byte out on its data
 * line and captures the master's byte, sampled in the bus clock domain.
 * Assumes a bit half-period well above the master's input sync lag.
 */
`timescale 1ns/1ps
module spi_slave_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Link from the master
    input  wire logic        serial_clock_i,
    input  wire logic        mosi_i,
    input  wire logic        sel_n_i,
    output logic             miso_o,
    output logic             sel_n_o,
    // Test control
    input  wire logic        fault_i,
    input  wire logic [7:0]  slave_byte_i,
    output logic [7:0]       got_o
);
    logic [7:0] sh_q;
    logic [7:0] rx_q;
    logic [3:0] cnt_q;
    logic       sck_q;
    logic       idle_q;

    // Select line has a pull-up; the bench pulls it low to fake a master
    assign sel_n_o = fault_i ? 1'b0 : 1'b1;
    // Unselected data line toggles so a stale bit is never read as valid
    assign miso_o  = sel_n_i ? idle_q : sh_q[7];

    always @(posedge sys_clk_i) begin
        sck_q  <= serial_clock_i;
        idle_q <= ~idle_q;
        if (rst_i) begin
            cnt_q  <= 4'h0;
            sh_q   <= slave_byte_i;
            idle_q <= 1'b0;
            got_o  <= 8'h00;
        end else if (serial_clock_i && !sck_q) begin
            rx_q  <= {rx_q[6:0], mosi_i};
            cnt_q <= cnt_q + 4'h1;
        end else if (!serial_clock_i && sck_q) begin
            if (cnt_q == 4'h8) begin
                got_o <= rx_q;
                cnt_q <= 4'h0;
                sh_q  <= slave_byte_i;
            end else begin
                sh_q <= {sh_q[6:0], 1'b0};
            end
        end else if (sel_n_i && cnt_q == 4'h0) begin
            sh_q <= slave_byte_i;
        end
    end
endmodule : spi_slave_model

// >>> tb.sv
/*
 * Self-checking bench for the serial rate, status and data block.
 * Assumes the constants header and the slave model are compiled first.
 */
`timescale 1ns/1ps
`include "spi_rate_consts.svh"
module tb;
    import spi_rate_pkg::*;
    typedef struct { logic [2:0] a; byte_t w; byte_t e; } row_t;
    logic       sys_clk_i, rst_i, reg_wr_i, reg_rd_i, fault;
    logic [2:0] reg_addr_i;
    byte_t      reg_wdata_i, reg_rdata_o, slave_byte, got, v;
    logic       sck, mosi, miso, sel_in_n, sel_n_o, sel_n_oe_o, irq_o;
    int         num_errors, n_tests, cyc, edges, t0, i;
    row_t       rows[5] = '{'{3'h2, 8'hFF, 8'h77}, '{3'h2, 8'h22, 8'h22},
        '{3'h3, 8'hFF, 8'h20}, '{3'h4, 8'hFF, 8'h00}, '{3'h7, 8'h00, 8'h00}};

    spi_rate_status_data_regs dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .serial_clock_o(sck), .mosi_o(mosi), .miso_i(miso),
        .sel_n_i(sel_in_n), .sel_n_o(sel_n_o), .sel_n_oe_o(sel_n_oe_o),
        .irq_o(irq_o));
    spi_slave_model slave (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .serial_clock_i(sck), .mosi_i(mosi), .sel_n_i(sel_n_o),
        .miso_o(miso), .sel_n_o(sel_in_n), .fault_i(fault),
        .slave_byte_i(slave_byte), .got_o(got));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sck) edges++;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task chk(input byte_t g, input byte_t e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [2:0] a, input byte_t d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [2:0] a, output byte_t d);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    task rdc(input logic [2:0] a, input byte_t e);
        rd(a, v);
        chk(v, e);
    endtask : rdc
    task wait_rx;
        v = 8'h00;
        for (int k = 0; k < 300 && v[7] !== 1'b1; k++) rd(3'h3, v);
        chk(v & 8'h80, 8'h80);
    endtask : wait_rx
    task final_report;
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    initial begin
        rst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0; fault = 1'b0;
        reg_addr_i = 3'h0; reg_wdata_i = 8'h00; slave_byte = 8'h3C;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(3'h5, 8'h00);
        rdc(3'h0, 8'h04);
        rdc(3'h3, 8'h20);
        for (i = 0; i < 5; i++) begin
            wr(rows[i].a, rows[i].w);
            rdc(rows[i].a, rows[i].e);
        end
        // Master, MSB first; a second write with no flag read is dropped
        wr(3'h0, 8'h10);
        rdc(3'h3, 8'h20);
        wr(3'h5, 8'hA5);
        wr(3'h5, 8'h66);
        @(posedge sys_clk_i);
        rdc(3'h3, 8'h20);
        @(posedge sck) t0 = $time;
        @(posedge sck) chk(8'((($time - t0) / 10)), 8'h18);
        wr(3'h2, 8'h22);
        wait_rx();
        chk(got, 8'hA5);
        rdc(3'h5, 8'h3C);
        rdc(3'h3, 8'h20);
        chk(8'(edges), 8'h08);
        // Queued byte follows at once; unread first byte survives overrun
        slave_byte = 8'h81;
        rdc(3'h3, 8'h20);
        wr(3'h5, 8'h11);
        @(posedge sys_clk_i);
        rdc(3'h3, 8'h20);
        wr(3'h5, 8'h22);
        slave_byte = 8'h42;
        for (i = 0; i < 900 && edges < 24; i++) @(posedge sys_clk_i);
        repeat (30) @(posedge sys_clk_i);
        chk(8'(edges), 8'h18);
        chk(got, 8'h22);
        rdc(3'h3, 8'hA0);
        rdc(3'h5, 8'h81);
        // Least significant bit first
        wr(3'h0, 8'h11);
        slave_byte = 8'h01;
        repeat (4) @(posedge sys_clk_i);
        rdc(3'h3, 8'h20);
        wr(3'h5, 8'h03);
        wait_rx();
        chk(got, 8'hC0);
        rdc(3'h5, 8'h80);
        // Interrupt from transmit-empty, then sticky events cleared by read
        wr(3'h0, 8'h20);
        @(posedge sys_clk_i);
        chk(8'(irq_o), 8'h01);
        wr(3'h0, 8'h00);
        @(posedge sys_clk_i);
        chk(8'(irq_o), 8'h00);
        rdc(3'h6, 8'h03);
        rdc(3'h6, 8'h00);
        wr(3'h7, 8'h01);
        @(posedge sys_clk_i);
        chk(8'(irq_o), 8'h00);
        // Mode fault only when the select pin is a fault input
        wr(3'h1, 8'h10);
        wr(3'h0, 8'h12);
        @(posedge sys_clk_i);
        chk(8'(sel_n_oe_o), 8'h01);
        fault <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        rdc(3'h3, 8'h20);
        fault <= 1'b0;
        wr(3'h0, 8'h10);
        repeat (10) @(posedge sys_clk_i);
        fault <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        fault <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        chk(8'(irq_o), 8'h00);
        wr(3'h7, 8'h04);
        @(posedge sys_clk_i);
        chk(8'(irq_o), 8'h01);
        rdc(3'h6, 8'h04);
        chk(8'(irq_o), 8'h00);
        wr(3'h0, 8'h10);
        rdc(3'h3, 8'h30);
        wr(3'h0, 8'h10);
        rdc(3'h3, 8'h20);
        final_report();
    end
endmodule : tb
